// ### common/scgwt_pkg.sv
// Constants and carrier types for the guard and wait timers.
// Assumes a byte-wide register port on the core clock.
package scgwt_pkg;

    // Register byte addresses
    localparam logic [15:0] ADDR_BGT = 16'hFE16;
    localparam logic [15:0] ADDR_EGT = 16'hFE17;
    localparam logic [15:0] ADDR_BW3 = 16'hFE18;
    localparam logic [15:0] ADDR_BW2 = 16'hFE19;
    localparam logic [15:0] ADDR_BW1 = 16'hFE1A;
    localparam logic [15:0] ADDR_BW0 = 16'hFE1B;
    localparam logic [15:0] ADDR_CW1 = 16'hFE1C;
    localparam logic [15:0] ADDR_CW0 = 16'hFE1D;
    localparam logic [15:0] ADDR_STAT = 16'hFE1E;
    localparam logic [15:0] ADDR_ATRH = 16'hFE1F;
    localparam logic [15:0] ADDR_ATRL = 16'hFE20;

    // Reset values
    localparam logic [7:0] EGT_RST = 8'h0C;
    localparam logic BGT_MSB_RST = 1'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [8:0] GUARD_CNT_RST = 9'h1FF;

    // Field positions and widths
    localparam int BGT_MSB_BIT = 7;
    localparam int BW3_BITS = 4;
    localparam int EGT_W = 9;
    localparam int WAIT_W = 28;
    localparam int CHAR_W = 16;
    localparam int ATR_W = 16;

    // Status register bits
    localparam int ST_WAIT_RUN = 0;
    localparam int ST_CHAR_RUN = 1;
    localparam int ST_ATR_RUN = 2;
    localparam int ST_TX_OK = 3;
    localparam int ST_ATR_SEEN = 4;

    // Character spacing floors in ETUs
    localparam logic [8:0] FLOOR_T0 = 9'h00C;
    localparam logic [8:0] FLOOR_T1 = 9'h00B;

    typedef struct packed {
        logic tx_start;
        logic rx_start;
        logic brk;
    } scgwt_evt_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scgwt_bus_t;

endpackage

// ### verilog/scgwt_wait_cnt.sv
// Restartable ETU wait counter with a one-cycle expiry pulse.
// Assumes tick, restart and stop come from logic on the core clock.
`timescale 1ns/1ps
module scgwt_wait_cnt #(
    parameter int W = 16
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic tick_in,
    input wire logic enable_in,
    input wire logic restart_in,
    input wire logic stop_in,
    input wire logic [W-1:0] limit_in,
    output logic running_out,
    output logic expired_out,
    output logic [W-1:0] count_out
);
    logic [W-1:0] count_r, count_nxt;
    logic run_r, run_nxt, exp_r, exp_nxt;
    wire hit = run_r & tick_in & (count_r >= limit_in);

    always_comb begin
        count_nxt = count_r;
        run_nxt = run_r;
        exp_nxt = 1'b0;
        if (restart_in && enable_in) begin
            count_nxt = '0;
            run_nxt = 1'b1;
        end else if (!enable_in || stop_in) begin
            run_nxt = 1'b0;
        end else if (hit) begin
            run_nxt = 1'b0;
            exp_nxt = 1'b1;
        end else if (run_r && tick_in) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_r <= '0;
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            run_r <= run_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign running_out = run_r;
    assign expired_out = exp_r;
    assign count_out = count_r;

    cnt_restart_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        restart_in && enable_in |=> run_r && count_r == '0)
        else $error("counter did not restart");
    cnt_expire_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        exp_r |-> $past(run_r) && $past(tick_in) && !run_r &&
        $past(count_r) >= $past(limit_in))
        else $error("expiry without exceeded count");
endmodule

// ### verilog/scgwt_guard.sv
// Extra guard time counter gating transmit start bits.
// Assumes one tick per ETU and a pulse per transmitted start bit.
`timescale 1ns/1ps
module scgwt_guard (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic tick_in,
    input wire logic tx_start_in,
    input wire logic t1_in,
    input wire logic brk_in,
    input wire logic [8:0] egt_in,
    output logic permit_out,
    output logic [8:0] count_out
);
    logic [8:0] count_r;
    wire [8:0] floor_w = t1_in ? scgwt_pkg::FLOOR_T1 : scgwt_pkg::FLOOR_T0;
    wire [8:0] need_w = (egt_in > floor_w) ? egt_in : floor_w;
    wire sat_w = &count_r;
    wire hold_w = !t1_in && brk_in;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_r <= scgwt_pkg::GUARD_CNT_RST;
        end else if (tx_start_in) begin
            count_r <= 9'h000;
        end else if (tick_in && !sat_w) begin
            count_r <= count_r + 9'h001;
        end
    end

    assign permit_out = (count_r >= need_w) && !hold_w;
    assign count_out = count_r;
endmodule

// ### verilog/scgwt_timers.sv
// Guard, wait, character and answer-to-reset timers of the card UART.
// Assumes an ETU tick, start-bit pulses and mode levels on the core clock.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module scgwt_timers (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire scgwt_pkg::scgwt_bus_t bus_in,
    output logic [7:0] rdata_out,
    input wire logic etu_tick_in,
    input wire logic protocol_t1_in,
    input wire logic receive_answer_reset_in,
    input wire scgwt_pkg::scgwt_evt_t evt_in,
    output logic tx_permit_out,
    output logic wait_timeout_out,
    output logic char_timeout_out,
    output logic atr_timeout_out
);
    ////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] egt_low_r;
    logic egt_msb_r;
    logic [3:0] bw3_r;
    logic [7:0] bw2_r, bw1_r, bw0_r;
    logic [7:0] cw1_r, cw0_r;
    logic [7:0] atrh_r, atrl_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic atr_seen_r;

    ////////////////////////////////////////////////////////////////////
    // Write decode
    wire wr_bgt = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_BGT;
    wire wr_egt = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_EGT;
    wire wr_bw3 = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_BW3;
    wire wr_bw2 = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_BW2;
    wire wr_bw1 = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_BW1;
    wire wr_bw0 = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_BW0;
    wire wr_cw1 = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_CW1;
    wire wr_cw0 = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_CW0;
    wire wr_atrh = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_ATRH;
    wire wr_atrl = bus_in.wr && bus_in.addr == scgwt_pkg::ADDR_ATRL;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            egt_low_r <= scgwt_pkg::EGT_RST;
            egt_msb_r <= scgwt_pkg::BGT_MSB_RST;
        end else begin
            if (wr_egt) egt_low_r <= bus_in.wdata;
            if (wr_bgt) egt_msb_r <= bus_in.wdata[scgwt_pkg::BGT_MSB_BIT];
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bw3_r <= scgwt_pkg::BYTE_RST[3:0];
            bw2_r <= scgwt_pkg::BYTE_RST;
            bw1_r <= scgwt_pkg::BYTE_RST;
            bw0_r <= scgwt_pkg::BYTE_RST;
        end else begin
            if (wr_bw3) bw3_r <= bus_in.wdata[scgwt_pkg::BW3_BITS-1:0];
            if (wr_bw2) bw2_r <= bus_in.wdata;
            if (wr_bw1) bw1_r <= bus_in.wdata;
            if (wr_bw0) bw0_r <= bus_in.wdata;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cw1_r <= scgwt_pkg::BYTE_RST;
            cw0_r <= scgwt_pkg::BYTE_RST;
            atrh_r <= scgwt_pkg::BYTE_RST;
            atrl_r <= scgwt_pkg::BYTE_RST;
        end else begin
            if (wr_cw1) cw1_r <= bus_in.wdata;
            if (wr_cw0) cw0_r <= bus_in.wdata;
            if (wr_atrh) atrh_r <= bus_in.wdata;
            if (wr_atrl) atrl_r <= bus_in.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assembled limits
    wire [8:0] egt_full = {egt_msb_r, egt_low_r};
    wire [27:0] wait_limit = {bw3_r, bw2_r, bw1_r, bw0_r};
    wire [15:0] char_limit = {cw1_r, cw0_r};
    wire [15:0] atr_limit = {atrh_r, atrl_r};

    ////////////////////////////////////////////////////////////////////
    // Guard time gate
    logic [8:0] guard_cnt;

    scgwt_guard u_guard (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .tick_in(etu_tick_in),
        .tx_start_in(evt_in.tx_start),
        .t1_in(protocol_t1_in),
        .brk_in(evt_in.brk),
        .egt_in(egt_full),
        .permit_out(tx_permit_out),
        .count_out(guard_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // Block or work wait timer
    wire wait_restart = evt_in.tx_start ||
        (!protocol_t1_in && evt_in.rx_start);
    wire wait_stop = protocol_t1_in && evt_in.rx_start;
    logic wait_run;
    logic [27:0] wait_cnt;

    scgwt_wait_cnt #(.W(scgwt_pkg::WAIT_W)) u_wait (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .tick_in(etu_tick_in),
        .enable_in(1'b1),
        .restart_in(wait_restart),
        .stop_in(wait_stop),
        .limit_in(wait_limit),
        .running_out(wait_run),
        .expired_out(wait_timeout_out),
        .count_out(wait_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // Character or initial wait timer
    wire char_en = protocol_t1_in || receive_answer_reset_in;
    logic char_run;
    logic [15:0] char_cnt;

    scgwt_wait_cnt #(.W(scgwt_pkg::CHAR_W)) u_char (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .tick_in(etu_tick_in),
        .enable_in(char_en),
        .restart_in(evt_in.rx_start),
        .stop_in(1'b0),
        .limit_in(char_limit),
        .running_out(char_run),
        .expired_out(char_timeout_out),
        .count_out(char_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // Answer-to-reset timer, started once by the first start bit
    wire atr_first = evt_in.rx_start && !atr_seen_r;
    logic atr_run;
    logic [15:0] atr_cnt;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            atr_seen_r <= 1'b0;
        end else if (!receive_answer_reset_in) begin
            atr_seen_r <= 1'b0;
        end else if (evt_in.rx_start) begin
            atr_seen_r <= 1'b1;
        end
    end

    scgwt_wait_cnt #(.W(scgwt_pkg::ATR_W)) u_atr (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .tick_in(etu_tick_in),
        .enable_in(receive_answer_reset_in),
        .restart_in(atr_first),
        .stop_in(1'b0),
        .limit_in(atr_limit),
        .running_out(atr_run),
        .expired_out(atr_timeout_out),
        .count_out(atr_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // Read path, data one cycle after the strobe
    wire [7:0] stat_w = {3'h0, atr_seen_r, tx_permit_out, atr_run,
        char_run, wait_run};

    always_comb begin
        rdata_nxt = 8'h00;
        case (bus_in.addr)
            scgwt_pkg::ADDR_BGT: rdata_nxt = {egt_msb_r, 7'h00};
            scgwt_pkg::ADDR_EGT: rdata_nxt = egt_low_r;
            scgwt_pkg::ADDR_BW3: rdata_nxt = {4'h0, bw3_r};
            scgwt_pkg::ADDR_BW2: rdata_nxt = bw2_r;
            scgwt_pkg::ADDR_BW1: rdata_nxt = bw1_r;
            scgwt_pkg::ADDR_BW0: rdata_nxt = bw0_r;
            scgwt_pkg::ADDR_CW1: rdata_nxt = cw1_r;
            scgwt_pkg::ADDR_CW0: rdata_nxt = cw0_r;
            scgwt_pkg::ADDR_STAT: rdata_nxt = stat_w;
            scgwt_pkg::ADDR_ATRH: rdata_nxt = atrh_r;
            scgwt_pkg::ADDR_ATRL: rdata_nxt = atrl_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_r <= 8'h00;
        end else if (bus_in.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata_out = rdata_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_tx_start;
        evt_in.tx_start;
    endsequence

    sequence s_wait_fresh;
        wait_run && wait_cnt == 28'h0000000;
    endsequence

    guard_egt_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        tx_permit_out |-> guard_cnt >= egt_full)
        else $error("start permitted before extra guard time");
    guard_floor_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        tx_permit_out |-> guard_cnt >= (protocol_t1_in ? 9'h00B : 9'h00C))
        else $error("start permitted below spacing floor");
    break_hold_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        !protocol_t1_in && evt_in.brk |-> !tx_permit_out)
        else $error("start permitted during break in T=0");
    guard_gap_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        s_tx_start |=> !tx_permit_out [*8])
        else $error("start permitted too soon after previous start");
    egt_read_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        bus_in.rd && bus_in.addr == scgwt_pkg::ADDR_EGT |=>
        rdata_out == $past(egt_low_r))
        else $error("extra guard low byte read mismatch");
    egt_msb_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        wr_bgt |=> egt_full[8] == $past(bus_in.wdata[7]))
        else $error("extra guard top bit not loaded");
    wait_load_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        wr_bw3 |=> wait_limit[27:24] == $past(bus_in.wdata[3:0]))
        else $error("wait value top nibble not loaded");
    t1_stop_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        protocol_t1_in && evt_in.rx_start && !evt_in.tx_start |=> !wait_run)
        else $error("block wait not stopped by received start");
    t1_arm_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        protocol_t1_in && evt_in.tx_start |=> s_wait_fresh)
        else $error("block wait not armed by sent character");
    t0_restart_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        !protocol_t1_in && (evt_in.tx_start || evt_in.rx_start)
        |=> s_wait_fresh)
        else $error("work wait not restarted by character edge");
    wait_pulse_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        wait_timeout_out |=> !wait_timeout_out)
        else $error("wait timeout longer than one cycle");
    char_arm_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        char_en && evt_in.rx_start |=> char_run && char_cnt == 16'h0000)
        else $error("character wait not restarted");
    char_to_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        char_timeout_out |-> $past(char_run) &&
        $past(char_cnt) >= $past(char_limit))
        else $error("character timeout without exceeded count");
    atr_off_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        !receive_answer_reset_in |=> !atr_run && !atr_seen_r)
        else $error("answer-to-reset timer runs while disabled");
    atr_once_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        atr_run && receive_answer_reset_in && evt_in.rx_start &&
        atr_cnt != 16'h0000 |=> atr_cnt != 16'h0000)
        else $error("answer-to-reset timer restarted by later character");
    atr_to_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        atr_timeout_out |-> $past(atr_run) &&
        $past(atr_cnt) >= $past(atr_limit))
        else $error("answer-to-reset timeout without exceeded count");
    rd_idle_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        !bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data not cleared after read cycle");
endmodule

// ### tb/scgwt_card_model.sv
// Card-side model: start-bit pulses spaced in ETUs and a break level.
// Assumes the bench drives the ETU tick and the go/gap/num commands.
`timescale 1ns/1ps
module scgwt_card_model (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic etu_tick_in,
    input wire logic go_in,
    input wire logic [15:0] gap_in,
    input wire logic [3:0] num_in,
    input wire logic brk_req_in,
    output logic rx_start_out,
    output logic brk_out
);
    logic [15:0] gap_cnt_r;
    logic [3:0] left_r;
    wire gap_done = (gap_cnt_r + 16'h0001) == gap_in;

    ////////////////////////////////////////////////////////////////////////
    // Character starts, gap_in ticks apart, first one gap_in after go
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gap_cnt_r <= 16'h0000;
            left_r <= 4'h0;
            rx_start_out <= 1'b0;
        end else begin
            rx_start_out <= 1'b0;
            if (go_in) begin
                gap_cnt_r <= 16'h0000;
                left_r <= num_in;
            end else if (left_r != 4'h0 && etu_tick_in) begin
                gap_cnt_r <= gap_done ? 16'h0000 : gap_cnt_r + 16'h0001;
                if (gap_done) begin
                    rx_start_out <= 1'b1;
                    left_r <= left_r - 4'h1;
                end
            end
        end
    end

    // Break signalling only on bench command
    assign brk_out = brk_req_in;
endmodule

// ### tb/smart_card_guard_wait_timers_tb_top.sv
// Self-checking bench for the guard and wait timers.
// Assumes the timers top, its package and the card model are compiled.
`timescale 1ns/1ps
module smart_card_guard_wait_timers_tb_top;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    scgwt_pkg::scgwt_bus_t bus = '0;
    scgwt_pkg::scgwt_evt_t evt;
    logic [7:0] rdata;
    logic [7:0] d;
    logic tick = 1'b0;
    logic t1 = 1'b0;
    logic rar = 1'b0;
    logic tx_start = 1'b0;
    logic go = 1'b0;
    logic [15:0] gap = 16'h0001;
    logic [3:0] num = 4'h0;
    logic brk_req = 1'b0;
    logic rx_start, brk, permit, wto, cto, ato;
    int err_count = 0;
    int comparisons = 0;
    int n_wto = 0;
    int n_cto = 0;
    int n_ato = 0;
    int b;
    logic [15:0] ra [11] = '{16'hFE16, 16'hFE17, 16'hFE18, 16'hFE19,
        16'hFE1A, 16'hFE1B, 16'hFE1C, 16'hFE1D, 16'hFE1F, 16'hFE20, 16'hFE30};
    logic [7:0] rv [11] = '{8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] wv [11] = '{8'h80, 8'hA5, 8'h05, 8'hA5, 8'hA5, 8'hA5,
        8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'h00};
    logic t_tab [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [8:0] e_tab [6] = '{9'h00C, 9'h005, 9'h005, 9'h00D, 9'h100,
        9'h000};

    assign evt = {tx_start, rx_start, brk};
    always #5 core_clk_in = ~core_clk_in;

    scgwt_timers i_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .bus_in(bus), .rdata_out(rdata), .etu_tick_in(tick),
        .protocol_t1_in(t1), .receive_answer_reset_in(rar), .evt_in(evt),
        .tx_permit_out(permit), .wait_timeout_out(wto),
        .char_timeout_out(cto), .atr_timeout_out(ato));

    scgwt_card_model i_card (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .etu_tick_in(tick), .go_in(go), .gap_in(gap), .num_in(num),
        .brk_req_in(brk_req), .rx_start_out(rx_start), .brk_out(brk));

    // Timeout pulse counters
    always @(posedge core_clk_in) begin
        n_wto += (wto === 1'b1);
        n_cto += (cto === 1'b1);
        n_ato += (ato === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus, event and compare tasks
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk_in);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge core_clk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge core_clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk_in);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t byte got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chkn(input int g, input int e);
        comparisons++;
        if (g != e) begin
            err_count++;
            $display("[FAIL] %0t count got %0d exp %0d", $time, g, e);
        end
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        rd(a, d);
        chk8(d, e);
    endtask

    task automatic etu(input int n);
        repeat (n) begin
            @(posedge core_clk_in);
            tick <= 1'b1;
            @(posedge core_clk_in);
            tick <= 1'b0;
        end
    endtask

    task automatic pulse_tx();
        @(posedge core_clk_in);
        tx_start <= 1'b1;
        @(posedge core_clk_in);
        tx_start <= 1'b0;
    endtask

    task automatic card(input logic [15:0] g, input logic [3:0] n);
        @(posedge core_clk_in);
        gap <= g;
        num <= n;
        go <= 1'b1;
        @(posedge core_clk_in);
        go <= 1'b0;
    endtask

    task automatic wr_wait(input logic [27:0] v);
        wr(16'hFE18, {4'h0, v[27:24]});
        wr(16'hFE19, v[23:16]);
        wr(16'hFE1A, v[15:8]);
        wr(16'hFE1B, v[7:0]);
    endtask

    task automatic settle(output int base, ref int cnt);
        repeat (3) @(posedge core_clk_in);
        base = cnt;
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #500000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        int x;
        int fl;
        repeat (16) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 11; i++) rchk(ra[i], rv[i]);
        for (int i = 0; i < 11; i++) wr(ra[i], 8'hA5);
        wr(16'hFE16, 8'hFF);
        for (int i = 0; i < 11; i++) rchk(ra[i], wv[i]);
        done("registers");
        for (int i = 0; i < 6; i++) begin
            fl = t_tab[i] ? 11 : 12;
            x = (int'(e_tab[i]) > fl) ? int'(e_tab[i]) : fl;
            wr(16'hFE16, {e_tab[i][8], 7'h00});
            wr(16'hFE17, e_tab[i][7:0]);
            t1 <= t_tab[i];
            pulse_tx();
            etu(x - 1);
            #1 chk8({7'h00, permit}, 8'h00);
            etu(1);
            #1 chk8({7'h00, permit}, 8'h01);
        end
        etu(1);
        t1 <= 1'b0;
        brk_req <= 1'b1;
        @(posedge core_clk_in);
        #1 chk8({7'h00, permit}, 8'h00);
        @(posedge core_clk_in);
        brk_req <= 1'b0;
        @(posedge core_clk_in);
        #1 chk8({7'h00, permit}, 8'h01);
        @(posedge core_clk_in);
        brk_req <= 1'b1;
        t1 <= 1'b1;
        @(posedge core_clk_in);
        #1 chk8({7'h00, permit}, 8'h01);
        @(posedge core_clk_in);
        brk_req <= 1'b0;
        done("guard");
        wr_wait(28'h0000003);
        pulse_tx();
        settle(b, n_wto);
        etu(3);
        chkn(n_wto - b, 0);
        etu(1);
        repeat (2) @(posedge core_clk_in);
        chkn(n_wto - b, 1);
        etu(5);
        chkn(n_wto - b, 1);
        pulse_tx();
        settle(b, n_wto);
        card(16'h0001, 4'h1);
        etu(10);
        chkn(n_wto - b, 0);
        done("block wait");
        wr_wait(28'h0000005);
        t1 <= 1'b0;
        pulse_tx();
        settle(b, n_wto);
        card(16'h0003, 4'h1);
        etu(8);
        chkn(n_wto - b, 0);
        etu(1);
        repeat (2) @(posedge core_clk_in);
        chkn(n_wto - b, 1);
        wr_wait(28'hFFFFFFF);
        rchk(16'hFE18, 8'h0F);
        rchk(16'hFE1B, 8'hFF);
        pulse_tx();
        settle(b, n_wto);
        etu(40);
        chkn(n_wto - b, 0);
        rd(16'hFE1E, d);
        chk8({7'h00, d[scgwt_pkg::ST_WAIT_RUN]}, 8'h01);
        done("work wait");
        wr(16'hFE1C, 8'h00);
        wr(16'hFE1D, 8'h02);
        t1 <= 1'b1;
        settle(b, n_cto);
        card(16'h0002, 4'h3);
        etu(8);
        chkn(n_cto - b, 0);
        etu(1);
        repeat (2) @(posedge core_clk_in);
        chkn(n_cto - b, 1);
        card(16'h0003, 4'h2);
        etu(6);
        repeat (2) @(posedge core_clk_in);
        chkn(n_cto - b, 2);
        etu(3);
        repeat (2) @(posedge core_clk_in);
        chkn(n_cto - b, 3);
        done("char wait");
        t1 <= 1'b0;
        wr(16'hFE1C, 8'h01);
        wr(16'hFE1F, 8'h00);
        wr(16'hFE20, 8'h04);
        rar <= 1'b1;
        settle(b, n_ato);
        card(16'h0002, 4'h3);
        etu(6);
        chkn(n_ato - b, 0);
        rd(16'hFE1E, d);
        chk8({7'h00, d[scgwt_pkg::ST_ATR_SEEN]}, 8'h01);
        etu(1);
        repeat (2) @(posedge core_clk_in);
        chkn(n_ato - b, 1);
        rar <= 1'b0;
        done("answer reset");
        end_sim();
    end
endmodule
